// ### design/canmc_pkg.sv
package canmc_pkg;
   // Word offsets on the bus
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_MODESEL = 4'h8;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'hC;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h0;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
   localparam logic [7:0] OFF_CONTROL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_MODESEL = 8'h08;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
   localparam logic [7:0] OFF_PRIO_EN = 8'h14;
   // Control field positions
   localparam int REQ_LSB = 5;
   localparam int ABORT_BIT = 4;
   localparam int WIN_LSB = 1;
   // Reset values
   localparam logic [7:0] CONTROL_RST = 8'h80;
   localparam logic [2:0] CUR_MODE_RST = 3'h4;
   localparam logic [1:0] FMODE_RST = 2'h0;
   // Event bit positions: err, tx_buffer_two, tx_buffer_one, tx_buffer_zero, rx_buffer_one, rx_buffer_zero, wake, prog0..5
   localparam int NEV = 13;
   localparam int EV_ERR = 0;
   localparam int EV_TX2 = 1;
   localparam int EV_TX1 = 2;
   localparam int EV_TX0 = 3;
   localparam int EV_RX1 = 4;
   localparam int EV_RX0 = 5;
   localparam int EV_WAKE = 6;
   localparam int EV_PROG = 7;
   localparam int NPROG = 6;

   typedef enum logic [2:0] {
      CANMC_NORMAL = 3'h0,
      CANMC_DISABLE = 3'h1,
      CANMC_LOOPBACK = 3'h2,
      CANMC_LISTEN = 3'h3,
      CANMC_CONFIG = 3'h4
   } canmc_mode_t;

   typedef enum logic [1:0] {
      CANMC_LEGACY = 2'h0,
      CANMC_ENH = 2'h1,
      CANMC_FIFO = 2'h2,
      CANMC_RSVD = 2'h3
   } canmc_fmode_t;

   // Legacy 3-bit codes
   localparam logic [2:0] LC_NONE = 3'h0;
   localparam logic [2:0] LC_ERR = 3'h1;
   localparam logic [2:0] LC_TX2 = 3'h2;
   localparam logic [2:0] LC_TX1 = 3'h3;
   localparam logic [2:0] LC_TX0 = 3'h4;
   localparam logic [2:0] LC_RX1 = 3'h5;
   localparam logic [2:0] LC_RX0 = 3'h6;
   localparam logic [2:0] LC_WAKE = 3'h7;
   // Enhanced 5-bit codes
   localparam logic [4:0] EC_NONE = 5'h00;
   localparam logic [4:0] EC_ERR = 5'h02;
   localparam logic [4:0] EC_TX2 = 5'h04;
   localparam logic [4:0] EC_TX1 = 5'h06;
   localparam logic [4:0] EC_TX0 = 5'h08;
   localparam logic [4:0] EC_WAKE = 5'h0E;
   localparam logic [4:0] EC_RX0 = 5'h10;
   localparam logic [4:0] EC_RX1 = 5'h11;
   localparam logic [4:0] EC_PROG0 = 5'h12;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } canmc_wb_req_t;
endpackage

// ### design/canmc_ctrl.sv
// Local design decisions: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
// Function
// - Request 1xx config, 011 listen, 010 loopback, 001 disable, 000 normal.
// - Current mode reports 100/011/010/001/000; codes 101..111 never appear.
// - Configuration mode entered only once the bus is idle.
// - Other modes take effect immediately, status follows promptly.
// - Abort-all bit 4 aborts pending transmissions in every transmit buffer.
// - Legacy window select bits 3-1 map buffers; bit 0 reads zero.
// - FIFO mode bits 3-0 give read pointer; enhanced legacy bits 4-0 zero.
// - Highest-priority pending source code lands in status bits 3-1 or 4-0.
// - Legacy codes: none, error, tx2, tx1, tx0, rx1, rx0 as 000..110.
// - Legacy wake-up interrupt reports code 111.
// - Enhanced five-bit codes: error, tx, wake, rx, programmable buffers.
// - FIFO mode: programmable buffer as receiver reports code 10000.
// - Legacy interrupt codes share the window select encoding.
// - Functional mode select: 00 legacy, 01 enhanced, 10 FIFO, 11 reserved.
module canmc_ctrl
   import canmc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire logic bus_idle_i,
   input wire logic [NEV-1:0] event_i,
   input wire logic [NPROG-1:0] prog_is_rx_i,
   input wire logic [3:0] fifo_ptr_i,
   output logic [2:0] current_op_mode_o,
   output logic abort_all_tx_o,
   output logic [4:0] window_select_o,
   output logic [1:0] functional_mode_select_o,
   output logic irq_o
);
   canmc_wb_req_t req;
   logic bus_idle_m;
   logic bus_idle_s;
   logic [7:0] controller_control;
   logic [1:0] functional_mode_select;
   logic [2:0] current_op_mode;
   logic [NEV-1:0] irq_status;
   logic [NEV-1:0] irq_mask;
   logic [NEV-1:0] prio_en;
   logic [NEV-1:0] pending;
   logic [2:0] next_legacy_code;
   logic [4:0] next_ext_code;
   logic [7:0] status_view;
   logic [7:0] control_view;
   logic wr_ok;
   logic rd_ok;
   logic hit;
   logic [31:0] next_rdata;
   logic [2:0] req_mode;

   assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                  sel: wb_sel_i, dat: wb_dat_i};
   assign hit = (req.adr == OFF_CONTROL) || (req.adr == OFF_STATUS) ||
                (req.adr == OFF_MODESEL) || (req.adr == OFF_IRQ_STAT) ||
                (req.adr == OFF_IRQ_MASK) || (req.adr == OFF_PRIO_EN);
   // Writes land on the edge where the master samples ack high
   assign wr_ok = req.cyc && req.stb && req.we && hit && wb_ack_o &&
                  req.sel[0];
   // Ack only once per request; the master drops stb after our ack
   assign rd_ok = req.cyc && req.stb && !wb_ack_o;

   // Idle level comes from the protocol engine, resynchronised anyway
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bus_idle_m <= 1'b0;
         bus_idle_s <= 1'b0;
      end else begin
         bus_idle_m <= bus_idle_i;
         bus_idle_s <= bus_idle_m;
      end
   end

   // Control register; abort bit is software owned
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         controller_control <= CONTROL_RST;
      end else if (wr_ok && req.adr == OFF_CONTROL) begin
         controller_control <= req.dat[7:0];
      end
   end

   // Mode select only changes while in configuration mode
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         functional_mode_select <= FMODE_RST;
      end else if (wr_ok && req.adr == OFF_MODESEL &&
                   current_op_mode == CANMC_CONFIG) begin
         functional_mode_select <= req.dat[1:0];
      end
   end

   assign req_mode = controller_control[REQ_LSB +: 3];

   // Mode tracking
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         current_op_mode <= CUR_MODE_RST;
      end else if (req_mode[2]) begin
         // Config waits for bus idle so no frame is cut
         if (bus_idle_s) begin
            current_op_mode <= CANMC_CONFIG;
         end
      end else begin
         current_op_mode <= req_mode;
      end
   end

   // Sticky events: set wins over write-one clear
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_status <= '0;
      end else if (wr_ok && req.adr == OFF_IRQ_STAT) begin
         irq_status <= (irq_status & ~req.dat[NEV-1:0]) | event_i;
      end else begin
         irq_status <= irq_status | event_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_mask <= '0;
      end else if (wr_ok && req.adr == OFF_IRQ_MASK) begin
         irq_mask <= req.dat[NEV-1:0];
      end
   end

   // Which pending sources are eligible for the source code
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         prio_en <= '0;
      end else if (wr_ok && req.adr == OFF_PRIO_EN) begin
         prio_en <= req.dat[NEV-1:0];
      end
   end

   assign pending = irq_status & prio_en;

   // Priority: error first, then tx2, tx1, tx0, rx1, rx0, wake, prog
   always_comb begin
      next_legacy_code = LC_NONE;
      if (pending[EV_ERR]) begin
         next_legacy_code = LC_ERR;
      end else if (pending[EV_TX2]) begin
         next_legacy_code = LC_TX2;
      end else if (pending[EV_TX1]) begin
         next_legacy_code = LC_TX1;
      end else if (pending[EV_TX0]) begin
         next_legacy_code = LC_TX0;
      end else if (pending[EV_RX1]) begin
         next_legacy_code = LC_RX1;
      end else if (pending[EV_RX0]) begin
         next_legacy_code = LC_RX0;
      end else if (pending[EV_WAKE]) begin
         next_legacy_code = LC_WAKE;
      end
   end

   always_comb begin
      next_ext_code = EC_NONE;
      for (int i = NPROG - 1; i >= 0; i--) begin
         if (pending[EV_PROG + i]) begin
            // FIFO mode folds receive buffers into one code
            if (functional_mode_select == CANMC_FIFO && prog_is_rx_i[i]) begin
               next_ext_code = EC_RX0;
            end else begin
               next_ext_code = EC_PROG0 + 5'(i);
            end
         end
      end
      if (pending[EV_WAKE]) begin
         next_ext_code = EC_WAKE;
      end
      if (pending[EV_RX0]) begin
         next_ext_code = EC_RX0;
      end
      if (pending[EV_RX1]) begin
         next_ext_code = EC_RX1;
      end
      if (pending[EV_TX0]) begin
         next_ext_code = EC_TX0;
      end
      if (pending[EV_TX1]) begin
         next_ext_code = EC_TX1;
      end
      if (pending[EV_TX2]) begin
         next_ext_code = EC_TX2;
      end
      if (pending[EV_ERR]) begin
         next_ext_code = EC_ERR;
      end
   end

   // Status view: code bits depend on functional mode
   always_comb begin
      status_view = {current_op_mode, 5'h00};
      if (functional_mode_select == CANMC_LEGACY) begin
         status_view[3:1] = next_legacy_code;
      end else if (functional_mode_select != CANMC_RSVD) begin
         status_view[4:0] = next_ext_code;
      end
   end

   // Control view: low bits are window, pointer or zero
   always_comb begin
      control_view = {controller_control[7:4], 4'h0};
      unique case (functional_mode_select)
         CANMC_LEGACY: control_view[3:1] = controller_control[3:1];
         CANMC_FIFO: control_view[3:0] = fifo_ptr_i;
         default: control_view[4:0] = 5'h00;
      endcase
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (req.adr)
         OFF_CONTROL: next_rdata[7:0] = control_view;
         OFF_STATUS: next_rdata[7:0] = status_view;
         OFF_MODESEL: next_rdata[1:0] = functional_mode_select;
         OFF_IRQ_STAT: next_rdata[NEV-1:0] = irq_status;
         OFF_IRQ_MASK: next_rdata[NEV-1:0] = irq_mask;
         OFF_PRIO_EN: next_rdata[NEV-1:0] = prio_en;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // One wait state: ack or err the cycle after the request appears
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= rd_ok && hit;
         wb_err_o <= rd_ok && !hit;
         wb_dat_o <= next_rdata;
      end
   end

   // Registered outputs to the rest of the controller
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         current_op_mode_o <= CUR_MODE_RST;
         abort_all_tx_o <= 1'b0;
         window_select_o <= 5'h00;
         functional_mode_select_o <= FMODE_RST;
         irq_o <= 1'b0;
      end else begin
         current_op_mode_o <= current_op_mode;
         abort_all_tx_o <= controller_control[ABORT_BIT];
         window_select_o <= {2'h0, controller_control[3:1]};
         functional_mode_select_o <= functional_mode_select;
         irq_o <= |(irq_status & irq_mask);
      end
   end
endmodule // canmc_ctrl

// ### dv/canmc_properties.sv
`timescale 1ns/100ps
module canmc_chk
   import canmc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic bus_idle_i,
   input wire logic [NEV-1:0] event_i,
   input wire logic [NPROG-1:0] prog_is_rx_i,
   input wire logic [3:0] fifo_ptr_i,
   input wire logic [2:0] current_op_mode_o,
   input wire logic abort_all_tx_o,
   input wire logic [4:0] window_select_o,
   input wire logic [1:0] functional_mode_select_o,
   input wire logic irq_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!nrst_i);
   wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   // Write strobe as the slave takes it: on the acked edge
   wire logic wack = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
      wb_sel_i[0];
   wire logic cwr = wack && wb_adr_i == OFF_CONTROL;
   reset_state_a:
      assert property ($rose(nrst_i) |-> current_op_mode_o == 3'h4 && !irq_o)
      else $error("state after reset wrong");
   mode_legal_a:
      assert property (current_op_mode_o <= 3'h4)
      else $error("reserved mode code reported");
   cfg_idle_a:
      assert property (!bus_idle_i [*4] ##0 current_op_mode_o != 3'h4
         |=> current_op_mode_o != 3'h4) else $error("config entered on busy bus");
   mode_fast_a:
      assert property (cwr && !wb_dat_i[7] |-> ##3
         current_op_mode_o == $past(wb_dat_i[7:5], 3))
      else $error("mode not taken");
   abort_bit_a:
      assert property (cwr |-> ##2 abort_all_tx_o == $past(wb_dat_i[4], 2))
      else $error("abort output wrong");
   win_top_a:
      assert property (window_select_o[4:3] == 2'h0)
      else $error("window select upper bits set");
   fmode_lock_a:
      assert property (wack && wb_adr_i == OFF_MODESEL &&
         current_op_mode_o != 3'h4 |=> $stable(functional_mode_select_o) [*2])
      else $error("mode select changed outside config");
   unmapped_a:
      assert property (req && wb_adr_i > OFF_PRIO_EN |=> wb_err_o && !wb_ack_o)
      else $error("unmapped access not refused");
   ack_pulse_a:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   cover property (cwr && !wb_dat_i[7]);
   cover property (irq_o);
   cover property (wb_err_o);
endmodule // canmc_chk
bind canmc_ctrl canmc_chk u_canmc_chk (.sys_clk_i, .nrst_i, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
   .wb_err_o, .bus_idle_i, .event_i, .prog_is_rx_i, .fifo_ptr_i,
   .current_op_mode_o, .abort_all_tx_o, .window_select_o,
   .functional_mode_select_o, .irq_o);

// ### dv/canmc_engine_model.sv
`timescale 1ns/100ps
module canmc_engine_model
   import canmc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic busy_i,
   input wire logic [NEV-1:0] fire_i,
   output logic bus_idle_o,
   output logic [NEV-1:0] event_o
);
   // Idle only while no frame is on the wire
   assign bus_idle_o = !busy_i;
   // Engine events are single-cycle pulses
   always_ff @(posedge sys_clk_i) begin
      event_o <= fire_i;
   end
endmodule // canmc_engine_model

// ### dv/tb.sv
`timescale 1ns/100ps
module tb
   import canmc_pkg::*;
;
   logic sys_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic busy = 1'b0;
   canmc_wb_req_t rq = '0;
   logic [NEV-1:0] fire = '0;
   logic [NEV-1:0] ev, m;
   logic [NPROG-1:0] prx = '0;
   logic [3:0] fptr = '0;
   logic [31:0] dat_o, ex;
   logic ack, err, idle, irq, abt;
   logic [2:0] cur;
   logic [4:0] win;
   logic [1:0] fms;
   logic [33:0] expq[$];
   int failures = 0;
   int checks = 0;
   always #5 sys_clk_i = ~sys_clk_i;
   canmc_engine_model u_canmc_engine_model (.sys_clk_i, .busy_i(busy),
      .fire_i(fire), .bus_idle_o(idle), .event_o(ev));
   canmc_ctrl u_canmc_ctrl (.sys_clk_i, .nrst_i, .wb_cyc_i(rq.cyc),
      .wb_stb_i(rq.stb), .wb_we_i(rq.we), .wb_adr_i(rq.adr),
      .wb_sel_i(rq.sel), .wb_dat_i(rq.dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .wb_err_o(err), .bus_idle_i(idle), .event_i(ev),
      .prog_is_rx_i(prx), .fifo_ptr_i(fptr), .current_op_mode_o(cur),
      .abort_all_tx_o(abt), .window_select_o(win),
      .functional_mode_select_o(fms), .irq_o(irq));
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Note: expectation queued before the request so the watcher never lags
   task automatic bus(input logic we, input logic [7:0] a,
         input logic [31:0] d, input logic c, input logic [31:0] e);
      int n;
      expq.push_back({c, a > OFF_PRIO_EN, e});
      @(posedge sys_clk_i);
      rq <= '{1'b1, 1'b1, we, a, 4'hF, d};
      n = 0;
      do @(posedge sys_clk_i); while (!(ack || err) && ++n < 50);
      rq <= '0;
      cmp({31'h0, ack || err}, 32'h1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 1'b1, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 1'b0, 32'h0);
   endtask
   task automatic fire_ev(input logic [NEV-1:0] f);
      @(posedge sys_clk_i);
      fire <= f;
      @(posedge sys_clk_i);
      fire <= '0;
      repeat (4) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
   endtask
   function automatic logic [4:0] code(input int i, input logic [1:0] fm);
      if (i < 7 && (fm == 2'h0 || i < 4))
         return 5'((i + 1) * 2);
      if (fm == 2'h0)
         return 5'h00;
      if (i == 4)
         return 5'h11;
      if (i == 5 || (fm == 2'h2 && prx[i-7]))
         return 5'h10;
      return i == 6 ? 5'h0E : 5'(i + 11);
   endfunction
   always @(posedge sys_clk_i) begin
      if ((ack || err) && expq.size() > 0) begin
         if (expq[0][33])
            cmp(err ? 32'hE : dat_o, expq[0][32] ? 32'hE : expq[0][31:0]);
         void'(expq.pop_front());
      end
   end
   task automatic print_verdict();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #300us;
      failures++;
      print_verdict();
   end
   initial begin
      void'($urandom(29));
      repeat (12) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      rd(OFF_STATUS, 32'h80);
      rd(OFF_IRQ_STAT, 32'h0);
      $display("reset test done");
      wr(OFF_PRIO_EN, 32'h1FFF);
      wr(OFF_IRQ_MASK, 32'h1FFF);
      for (int fm = 0; fm < 3; fm++) begin
         prx <= NPROG'($urandom);
         fptr <= 4'($urandom % 8);
         wr(OFF_MODESEL, 32'(fm));
         wr(OFF_CONTROL, 32'h8F);
         ex = fm == 0 ? 32'h8E : fm == 1 ? 32'h80 : {28'h8, fptr};
         rd(OFF_CONTROL, ex);
         cmp({27'h0, win}, 32'h7);
         for (int i = 0; i < NEV; i++) begin
            m = (NEV'($urandom) << i) | (NEV'(1) << i);
            fire_ev(m);
            cmp({31'h0, irq}, 32'h1);
            ex = {27'h4, code(i, 2'(fm))};
            rd(OFF_STATUS, ex);
            if (fm == 0)
               wr(OFF_CONTROL, 32'h80 | 32'(ex[3:0]));
            wr(OFF_IRQ_STAT, 32'(m));
            if (fm == 0)
               cmp({27'h0, win}, 32'(ex[3:1]));
         end
      end
      wr(OFF_IRQ_MASK, 32'h0);
      fire_ev(NEV'(1));
      cmp({31'h0, irq}, 32'h0);
      rd(OFF_IRQ_STAT, 32'h1);
      wr(OFF_IRQ_STAT, 32'h1);
      wr(OFF_IRQ_MASK, 32'h1FFF);
      $display("code test done");
      busy <= 1'b1;
      for (int md = 3; md >= 0; md--) begin
         wr(OFF_CONTROL, 32'(md) << 5);
         rd(OFF_STATUS, 32'(md) << 5);
         cmp({29'h0, cur}, 32'(md));
      end
      wr(OFF_MODESEL, 32'h0);
      rd(OFF_MODESEL, 32'h2);
      cmp({30'h0, fms}, 32'h2);
      wr(OFF_CONTROL, 32'h10);
      repeat (2) @(negedge sys_clk_i);
      cmp({31'h0, abt}, 32'h1);
      wr(OFF_CONTROL, 32'h80);
      repeat (10) @(negedge sys_clk_i);
      cmp({31'h0, abt}, 32'h0);
      rd(OFF_STATUS, 32'h0);
      busy <= 1'b0;
      repeat (6) @(posedge sys_clk_i);
      rd(OFF_STATUS, 32'h80);
      rd(8'h18, 32'h0);
      $display("mode test done");
      print_verdict();
   end
endmodule // tb
